// *** pkg/sbst_pkg.sv ***
// Constants, codes and state type for the SRAM boundary scan test port
package sbst_pkg;
    // Instruction register width
    localparam int SBST_IR_W = 3;
    // Identification register width
    localparam int SBST_ID_W = 32;
    // Instruction codes
    localparam logic [2:0] SBST_INS_EXTEST = 3'h0;
    localparam logic [2:0] SBST_INS_IDCODE = 3'h1;
    localparam logic [2:0] SBST_INS_SAMPZ = 3'h2;
    localparam logic [2:0] SBST_INS_SAMPLE = 3'h4;
    localparam logic [2:0] SBST_INS_BYPASS = 3'h7;
    // Value loaded into the instruction shifter at capture
    localparam logic [2:0] SBST_IR_CAPTURE = 3'h1;
    // Instruction held after reset
    localparam logic [2:0] SBST_IR_RESET = SBST_INS_IDCODE;
    // Bypass value after capture or reset
    localparam logic SBST_BYP_RESET = 1'b0;
    // Synchroniser depth
    localparam int SBST_SYNC_STAGES = 2;
    // Controller states, Gray steps along the scan paths
    typedef enum logic [3:0] {
        SBST_TLR = 4'h0,
        SBST_RTI = 4'h1,
        SBST_SELDR = 4'h3,
        SBST_CAPDR = 4'h2,
        SBST_SHDR = 4'h6,
        SBST_EX1DR = 4'h7,
        SBST_PSDR = 4'h5,
        SBST_EX2DR = 4'h4,
        SBST_UPDR = 4'hC,
        SBST_SELIR = 4'hD,
        SBST_CAPIR = 4'hF,
        SBST_SHIR = 4'hE,
        SBST_EX1IR = 4'hA,
        SBST_PSIR = 4'hB,
        SBST_EX2IR = 4'h9,
        SBST_UPIR = 4'h8
    } sbst_state_t;
endpackage

// *** verilog/sbst_sync.sv ***
// Multi-bit two-flop synchroniser with asynchronous clear
`timescale 1ns/1ps
`default_nettype none
module sbst_sync
    import sbst_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // Chain of both stages, first stage read only by the second
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sbst_sync_t;

    sbst_sync_t s_q; // Registered state
    sbst_sync_t s_d; // Next state

    // Shift the chain one stage
    always_comb
    begin
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    // Registers clear to zero under reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;
endmodule
`default_nettype wire

// *** verilog/sbst_tap.sv ***
// Boundary scan test access port with controller and scan registers
`timescale 1ns/1ps
`default_nettype none
module sbst_tap
    import sbst_pkg::*;
#(
    parameter int BSR_LEN = 16,
    parameter logic [31:0] ID_CODE = 32'h0A5A_5001 // Arbitrary value
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_o,
    output logic tdo_oe,
    output logic tms_pullup,
    output logic tdi_pullup,
    input wire logic [BSR_LEN-1:0] ring_in,
    output logic [BSR_LEN-1:0] ring_drive,
    output logic ring_extest,
    output logic ring_highz
);
    import sbst_pkg::*;

    // Rising-edge test clock state
    typedef struct packed {
        sbst_state_t st;
        logic [SBST_IR_W-1:0] irs;
        logic [SBST_IR_W-1:0] ir;
        logic byp;
        logic [SBST_ID_W-1:0] idr;
        logic [BSR_LEN-1:0] bsr;
        logic [BSR_LEN-1:0] upd;
        logic upd_tgl;
    } sbst_tck_t;

    // Falling-edge output state
    typedef struct packed {
        logic tdo;
        logic oe;
    } sbst_out_t;

    // System clock state
    typedef struct packed {
        logic tgl_seen;
        logic [BSR_LEN-1:0] drive;
    } sbst_sys_t;

    sbst_tck_t t_q; // Test clock registers
    sbst_tck_t t_d; // Their next values
    sbst_out_t o_q; // Output registers
    sbst_out_t o_d; // Their next values
    sbst_sys_t s_q; // System registers
    sbst_sys_t s_d; // Their next values
    logic sys_rst_n; // Reset released on clk
    logic tck_rst_n; // Reset released on tck
    logic [BSR_LEN-1:0] ring_tck; // Ring values on tck
    logic tgl_sys; // Update toggle on clk
    logic [1:0] mode_sys; // Extest and high-Z on clk
    logic ins_bsr; // Boundary register selected
    logic ins_id; // Identify register selected
    logic serial_out; // Selected register LSB

    // Reset release into system domain
    sbst_sync #(
        .WIDTH(1)
    ) u_rst_sys (
        .clk(clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(sys_rst_n)
    );

    // Power-up reset released on test clock
    sbst_sync #(
        .WIDTH(1)
    ) u_rst_tck (
        .clk(tck),
        .rst_n(resetn),
        .d(1'b1),
        .q(tck_rst_n)
    );

    // Ring values brought onto test clock
    sbst_sync #(
        .WIDTH(BSR_LEN)
    ) u_ring (
        .clk(tck),
        .rst_n(tck_rst_n),
        .d(ring_in),
        .q(ring_tck)
    );

    // Update toggle brought onto system clock
    sbst_sync #(
        .WIDTH(1)
    ) u_tgl (
        .clk(clk),
        .rst_n(sys_rst_n),
        .d(t_q.upd_tgl),
        .q(tgl_sys)
    );

    // Mode levels brought onto system clock
    sbst_sync #(
        .WIDTH(2)
    ) u_mode (
        .clk(clk),
        .rst_n(sys_rst_n),
        .d({t_q.ir == SBST_INS_EXTEST, t_q.ir == SBST_INS_SAMPZ}),
        .q(mode_sys)
    );

    // Pad pull-ups always requested
    assign tms_pullup = 1'b1;
    assign tdi_pullup = 1'b1;

    // Instruction decode, reserved codes act as bypass
    always_comb
    begin
        ins_bsr = 1'b0;
        ins_id = 1'b0;
        unique case (t_q.ir)
            SBST_INS_EXTEST, SBST_INS_SAMPZ, SBST_INS_SAMPLE: ins_bsr = 1'b1;
            SBST_INS_IDCODE: ins_id = 1'b1;
            default: ins_bsr = 1'b0; // Bypass and reserved
        endcase
    end

    // Serial output source, one register at a time
    always_comb
    begin
        if (t_q.st == SBST_SHIR)
        begin
            serial_out = t_q.irs[0];
        end
        else if (ins_bsr)
        begin
            serial_out = t_q.bsr[0];
        end
        else if (ins_id)
        begin
            serial_out = t_q.idr[0];
        end
        else
        begin
            serial_out = t_q.byp;
        end
    end

    // Controller moves and register actions
    always_comb
    begin
        t_d = t_q;
        // Next state from sampled mode select
        unique case (t_q.st)
            SBST_TLR: t_d.st = tms ? SBST_TLR : SBST_RTI;
            SBST_RTI: t_d.st = tms ? SBST_SELDR : SBST_RTI;
            SBST_SELDR: t_d.st = tms ? SBST_SELIR : SBST_CAPDR;
            SBST_CAPDR: t_d.st = tms ? SBST_EX1DR : SBST_SHDR;
            SBST_SHDR: t_d.st = tms ? SBST_EX1DR : SBST_SHDR;
            SBST_EX1DR: t_d.st = tms ? SBST_UPDR : SBST_PSDR;
            SBST_PSDR: t_d.st = tms ? SBST_EX2DR : SBST_PSDR;
            SBST_EX2DR: t_d.st = tms ? SBST_UPDR : SBST_SHDR;
            SBST_UPDR: t_d.st = tms ? SBST_SELDR : SBST_RTI;
            SBST_SELIR: t_d.st = tms ? SBST_TLR : SBST_CAPIR;
            SBST_CAPIR: t_d.st = tms ? SBST_EX1IR : SBST_SHIR;
            SBST_SHIR: t_d.st = tms ? SBST_EX1IR : SBST_SHIR;
            SBST_EX1IR: t_d.st = tms ? SBST_UPIR : SBST_PSIR;
            SBST_PSIR: t_d.st = tms ? SBST_EX2IR : SBST_PSIR;
            SBST_EX2IR: t_d.st = tms ? SBST_UPIR : SBST_SHIR;
            SBST_UPIR: t_d.st = tms ? SBST_SELDR : SBST_RTI;
        endcase
        // Actions of the present state
        unique case (t_q.st)
            SBST_TLR:
            begin
                t_d.ir = SBST_IR_RESET;
                t_d.byp = SBST_BYP_RESET;
            end
            SBST_CAPIR:
            begin
                t_d.irs = SBST_IR_CAPTURE;
            end
            SBST_SHIR:
            begin
                t_d.irs = {tdi, t_q.irs[SBST_IR_W-1:1]};
            end
            SBST_UPIR:
            begin
                t_d.ir = t_q.irs;
                if (t_q.irs == SBST_INS_BYPASS)
                begin
                    t_d.byp = SBST_BYP_RESET;
                end
            end
            SBST_CAPDR:
            begin
                if (ins_bsr)
                begin
                    t_d.bsr = ring_tck;
                end
                else if (ins_id)
                begin
                    t_d.idr = ID_CODE;
                end
                else
                begin
                    t_d.byp = SBST_BYP_RESET;
                end
            end
            SBST_SHDR:
            begin
                if (ins_bsr)
                begin
                    t_d.bsr = {tdi, t_q.bsr[BSR_LEN-1:1]};
                end
                else if (ins_id)
                begin
                    t_d.idr = {tdi, t_q.idr[SBST_ID_W-1:1]};
                end
                else
                begin
                    t_d.byp = tdi;
                end
            end
            SBST_UPDR:
            begin
                if (ins_bsr)
                begin
                    t_d.upd = t_q.bsr;
                    t_d.upd_tgl = ~t_q.upd_tgl;
                end
            end
            default:
            begin
                t_d.irs = t_q.irs; // Hold in other states
            end
        endcase
    end

    // Test clock rising edge registers
    always_ff @(posedge tck or negedge tck_rst_n)
    begin
        if (!tck_rst_n)
        begin
            t_q.st <= SBST_TLR;
            t_q.irs <= SBST_IR_CAPTURE;
            t_q.ir <= SBST_IR_RESET;
            t_q.byp <= SBST_BYP_RESET;
            t_q.idr <= '0;
            t_q.bsr <= '0;
            t_q.upd <= '0;
            t_q.upd_tgl <= 1'b0;
        end
        else
        begin
            t_q <= t_d;
        end
    end

    // Output value and enable for the falling edge
    always_comb
    begin
        o_d.tdo = serial_out;
        o_d.oe = (t_q.st == SBST_SHDR) || (t_q.st == SBST_SHIR);
    end

    // Test clock falling edge registers
    always_ff @(negedge tck or negedge tck_rst_n)
    begin
        if (!tck_rst_n)
        begin
            o_q <= '0;
        end
        else
        begin
            o_q <= o_d;
        end
    end

    assign tdo_o = o_q.tdo;
    assign tdo_oe = o_q.oe;

    // Take the update word once its toggle arrives
    always_comb
    begin
        s_d = s_q;
        s_d.tgl_seen = tgl_sys;
        if (tgl_sys != s_q.tgl_seen)
        begin
            s_d.drive = t_q.upd; // Stable since the toggle
        end
    end

    // System clock registers
    always_ff @(posedge clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Ring controls; reset keeps them idle so memory runs on
    assign ring_drive = s_q.drive;
    assign ring_extest = mode_sys[1];
    assign ring_highz = mode_sys[0];
endmodule
`default_nettype wire

// *** tb/sbst_tap_sva.sv ***
// Pin-level assertions for the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdo_oe,
    input wire logic tms_pullup,
    input wire logic tdi_pullup,
    input wire logic ring_extest,
    input wire logic ring_highz
);
    // Pad pull-up requests never drop
    a_tms_pull_on: assert property (@(posedge clk) disable iff (!resetn) tms_pullup)
        else $error("tms pull-up request low");
    a_tdi_pull_on: assert property (@(posedge clk) disable iff (!resetn) tdi_pullup)
        else $error("tdi pull-up request low");
    // Serial output floats as reset lets go
    a_oe_powerup_off: assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> !tdo_oe)
        else $error("tdo driven after power-up");
    // Five high mode-select edges end any shift
    a_tap_five_high: assert property (@(posedge tck) disable iff (!resetn)
        tms [*5] |=> !tdo_oe)
        else $error("tdo driven after five high tms");
    // Shift entered with tms low, from capture or from the second exit
    a_oe_enter_shift: assert property (@(posedge tck) disable iff (!resetn)
        $rose(tdo_oe) |-> !$past(tms) && ($past(tms, 2) != $past(tms, 3)))
        else $error("tdo enabled without capture path");
    // Shift left only with tms high
    a_oe_leave_shift: assert property (@(posedge tck) disable iff (!resetn)
        $fell(tdo_oe) |-> $past(tms))
        else $error("tdo released with tms low");
    // Low tms keeps the shift state driving
    a_oe_hold_shift: assert property (@(posedge tck) disable iff (!resetn)
        tdo_oe && !tms |=> tdo_oe)
        else $error("tdo released inside shift");
    // Ring modes never both active
    a_ring_one_mode: assert property (@(posedge clk) disable iff (!resetn)
        !(ring_extest && ring_highz))
        else $error("extest and high-z both active");
    // Main scenarios reached
    c_shift: cover property (@(posedge tck) disable iff (!resetn) $rose(tdo_oe));
    c_extest: cover property (@(posedge clk) disable iff (!resetn) $rose(ring_extest));
    c_highz: cover property (@(posedge clk) disable iff (!resetn) $rose(ring_highz));
endmodule
bind sbst_tap sbst_tap_sva u_sva (
    .clk(clk),
    .resetn(resetn),
    .tck(tck),
    .tms(tms),
    .tdo_oe(tdo_oe),
    .tms_pullup(tms_pullup),
    .tdi_pullup(tdi_pullup),
    .ring_extest(ring_extest),
    .ring_highz(ring_highz)
);
`default_nettype wire

// *** tb/sbst_host.sv ***
// Model of the external scan controller driving the test port
`timescale 1ns/1ps
`default_nettype none
module sbst_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe
);
    logic seen; // Serial output taken at the rising edge
    // Clock parked low, lines at pull-up level
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One test clock period, lines set after the fall
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #15 tck = 1'b1;
        seen = tdo_oe ? tdo_o : 1'bz;
        #15 tck = 1'b0;
    endtask
    // Reset state to idle
    task automatic idle();
        step(1'b0, 1'b1);
    endtask
    // Five high mode-select edges
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b1);
    endtask
    // Full scan from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        dout = 64'h0;
        step(1'b1, 1'b1);
        if (ir)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i]);
            dout[i] = seen;
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        tms = 1'b1; // Released lines return to pull-up level
        tdi = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/sram_boundary_scan_tap_tb.sv ***
// Self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap_tb;
    import sbst_pkg::*;
    localparam int BSR = 16;
    localparam logic [31:0] ID = 32'h1234_5679; // Arbitrary value
    logic clk;
    logic resetn;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_o;
    logic tdo_oe;
    logic [BSR-1:0] ring_in;
    logic [BSR-1:0] ring_drive;
    logic ring_extest;
    logic ring_highz;
    logic [63:0] got; // Bits read back from a scan
    logic [63:0] din; // Bits sent in a scan
    logic [BSR-1:0] exp_ring; // Ring value the capture should see
    logic [2:0] codes [4]; // Instruction table
    int fail_count;
    int num_checks;
    int rnd;
    sbst_tap #(.BSR_LEN(BSR), .ID_CODE(ID)) u_dut (
        .clk(clk),
        .resetn(resetn),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo_o(tdo_o),
        .tdo_oe(tdo_oe),
        .tms_pullup(),
        .tdi_pullup(),
        .ring_in(ring_in),
        .ring_drive(ring_drive),
        .ring_extest(ring_extest),
        .ring_highz(ring_highz)
    );
    sbst_host u_host (
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo_o(tdo_o),
        .tdo_oe(tdo_oe)
    );
    // System clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #1ms;
        fail_count++;
        close_out();
    end
    // Main sequence
    initial
    begin
        rnd = $urandom(69);
        resetn = 1'b0;
        ring_in = 16'h0000;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // Test clock reset lets go only after two test clock rises
        u_host.tap_reset();
        u_host.idle();
        u_host.scan(1'b0, 32, 64'h0, got);
        chk(got[31:0], ID);
        codes = '{SBST_INS_BYPASS, 3'h3, 3'h5, 3'h6};
        // Bypass and reserved codes give a one-bit path
        foreach (codes[i])
        begin
            u_host.scan(1'b1, 3, {61'h0, codes[i]}, got);
            chk({29'h0, got[2:0]}, {29'h0, SBST_IR_CAPTURE});
            din = {32'h0, $urandom};
            u_host.scan(1'b0, 8, din, got);
            chk({24'h0, got[7:0]}, {24'h0, din[6:0], 1'b0});
        end
        codes = '{SBST_INS_SAMPLE, SBST_INS_EXTEST, SBST_INS_SAMPZ, SBST_INS_BYPASS};
        // Boundary instructions capture the ring and update it
        for (int i = 0; i < 3; i++)
        begin
            exp_ring = 16'($urandom);
            @(posedge clk) ring_in <= exp_ring;
            repeat (4) @(posedge clk);
            u_host.scan(1'b1, 3, {61'h0, codes[i]}, got);
            din = {48'h0, 16'($urandom)};
            u_host.scan(1'b0, BSR, din, got);
            chk({16'h0, got[15:0]}, {16'h0, exp_ring});
            repeat (8) @(posedge clk);
            chk({16'h0, ring_drive}, din[31:0]);
            chk({31'h0, ring_extest}, {31'h0, codes[i] == SBST_INS_EXTEST});
            chk({31'h0, ring_highz}, {31'h0, codes[i] == SBST_INS_SAMPZ});
        end
        u_host.tap_reset();
        u_host.idle();
        repeat (4) @(posedge clk);
        chk({30'h0, ring_extest, ring_highz}, 32'h0);
        u_host.scan(1'b0, 32, 64'h0, got);
        chk(got[31:0], ID);
        close_out();
    end
endmodule
`default_nettype wire
